// ### audio_source.sv
`timescale 1ns/1ps
// Audio source on the nine shared pins; the bit clock is slow
// against the core clock so the pin synchronisers see every edge
module audio_source (
  input  wire logic       ref_clk_in,
  input  wire logic       dsd_in,
  output logic [8:0]      pins_out
);
  logic [7:0] div = 8'h00;

  // Free divider: bit clock is div[2], PCM frame is div[7]
  always_ff @(posedge ref_clk_in) begin
    div <= div + 8'h01;
  end

  // PCM: clock, frame, steady data, unused pins at a known level
  // DSD: left 1 changes every bit so the frame pin looks busy
  always_comb begin
    if (dsd_in) begin
      pins_out = {7'h56, div[3], div[2]};
    end else begin
      pins_out = {3'b101, 4'ha, div[7], div[2]};
    end
  end
endmodule : audio_source

// ### auto_detect.sv
`timescale 1ns/1ps
`include "mode_cfg.svh"
// Tells PCM from DSD by how often the shared frame pin changes,
// measured in rising edges of the shared clock pin
module auto_detect #(
  parameter int GAP_MAX = `DSD_GAP_MAX
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic clear_in,
  input  wire logic clk_pin_in,
  input  wire logic frame_pin_in,
  output logic      dsd_seen_out
);
  logic       clk_d;
  logic       frame_d;
  logic [7:0] gap;

  if (GAP_MAX < 2 || GAP_MAX > 200) begin : g_chk
    $error("auto_detect: GAP_MAX out of range");
  end

  // Edge history of already synchronised pins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_d   <= 1'b0;
      frame_d <= 1'b0;
    end else begin
      clk_d   <= clk_pin_in;
      frame_d <= frame_pin_in;
    end
  end

  // Saturating gap count; a PCM frame clock spans many bit clocks,
  // a bitstream changes within a few
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap          <= 8'h00;
      dsd_seen_out <= 1'b0;
    end else if (clear_in) begin
      gap          <= 8'h00;
      dsd_seen_out <= 1'b0;
    end else if (frame_pin_in != frame_d) begin
      dsd_seen_out <= (gap < 8'(GAP_MAX));
      gap          <= 8'h00;
    end else if (clk_pin_in && !clk_d && gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
endmodule : auto_detect

// ### conv_mode_ctrl.sv
`timescale 1ns/1ps
`include "mode_cfg.svh"
module conv_mode_ctrl
  import mode_pkg::*;
#(
  parameter int DSD_RATIO = `DSD_RATIO,
  parameter int SWITCH_FS = `SWITCH_FS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        power_down_n_in,
  input  wire logic        bus_select_in,
  input  wire logic        pin_mode_strap_in,
  input  wire logic [2:0]  pin_audio_format_in,
  input  wire logic [1:0]  pin_multislot_in,
  input  wire logic        pin_soft_mute_in,
  input  wire logic [8:0]  shared_pin_in,
  output logic [1:0]       control_mode_out,
  output logic             conv_is_dsd_out,
  output logic             switching_out,
  output logic             soft_reset_n_out,
  output logic             clock_setting_auto_out,
  output logic [2:0]       audio_format_out,
  output logic [1:0]       multislot_out,
  output logic             soft_mute_out,
  output logic [7:0]       zero_detect_en_out,
  output logic [7:0]       invert_out,
  output logic [3:0]       channel_pick_out,
  output logic             bit_clock_out,
  output logic             frame_clock_out,
  output logic [3:0]       serial_data_out,
  output logic             bitstream_clock_out,
  output logic [3:0]       bitstream_left_out,
  output logic [3:0]       bitstream_right_out
);
  localparam int NS = 18;

  if (SWITCH_FS < 2 || SWITCH_FS > 3 || DSD_RATIO < 2 ||
      DSD_RATIO > 255) begin : g_chk
    $error("conv_mode_ctrl: unsupported parameter");
  end

  // Two-flop synchronisers; only sync2 feeds logic
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {power_down_n_in, bus_select_in, pin_mode_strap_in,
                pin_audio_format_in, pin_multislot_in,
                pin_soft_mute_in, shared_pin_in};
      sync2 <= sync1;
    end
  end

  logic       pdn_s;
  logic       bus_s;
  logic       strap_s;
  logic [2:0] pfmt_s;
  logic [1:0] pslot_s;
  logic       pmute_s;
  logic [8:0] pin_s;
  assign {pdn_s, bus_s, strap_s, pfmt_s, pslot_s, pmute_s, pin_s} = sync2;

  function automatic ctl_mode_e decode_ctl(input logic bus_sel,
                                           input logic strap);
    if (!bus_sel) begin
      decode_ctl = ctl_serial3;
    end else if (!strap) begin
      decode_ctl = ctl_twowire;
    end else begin
      decode_ctl = ctl_pin;
    end
  endfunction : decode_ctl

  // Straps caught on power-down release; a strap moved later is ignored
  ctl_mode_e ctl_mode;
  logic      pdn_d;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pdn_d    <= 1'b0;
      ctl_mode <= ctl_serial3;
    end else begin
      pdn_d <= pdn_s;
      if (pdn_s && !pdn_d) begin
        ctl_mode <= decode_ctl(bus_s, strap_s);
      end
    end
  end
  logic pin_ctl;
  assign pin_ctl = (ctl_mode == ctl_pin);

  // Register fields; power-down returns every field to its default
  logic       soft_reset_n;
  logic [2:0] reg_format;
  logic       reg_clock_auto;
  logic       reg_mute;
  logic       conv_mode_sel;
  logic [3:0] channel_pick;
  logic [7:0] left_invert;
  logic [7:0] zero_en;
  logic [1:0] reg_slot;
  logic       auto_conv_switch_en;

  logic [4:0] idx;
  logic       mapped;
  logic       wr_en;
  assign idx   = paddr_in[6:2];
  assign wr_en = psel_in && penable_in && pwrite_in && mapped;

  function automatic logic is_mapped(input logic [4:0] i);
    case (i)
      `IDX_CLOCK_FORMAT, `IDX_MUTE, `IDX_CONV_SEL, `IDX_INVERT_A,
      `IDX_ZERO_LEFT, `IDX_ZERO_RIGHT, `IDX_SLOT_FORMAT,
      `IDX_INVERT_B, `IDX_PICK_B, `IDX_AUTO_SWITCH: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped
  assign mapped = is_mapped(idx) && (paddr_in[7] == 1'b0) &&
                  (paddr_in[1:0] == 2'b00);

  // Register writes
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_reset_n        <= `RST_SOFT_RESET_N;
      reg_format          <= `RST_FORMAT;
      reg_clock_auto      <= `RST_CLOCK_AUTO;
      reg_mute            <= `RST_MUTE;
      conv_mode_sel       <= `RST_CONV_SEL;
      channel_pick        <= `RST_PICK;
      left_invert         <= `RST_INVERT;
      zero_en             <= `RST_ZERO;
      reg_slot            <= `RST_SLOT;
      auto_conv_switch_en <= `RST_AUTO_SWITCH;
    end else if (!pdn_s) begin
      soft_reset_n        <= `RST_SOFT_RESET_N;
      reg_format          <= `RST_FORMAT;
      reg_clock_auto      <= `RST_CLOCK_AUTO;
      reg_mute            <= `RST_MUTE;
      conv_mode_sel       <= `RST_CONV_SEL;
      channel_pick        <= `RST_PICK;
      left_invert         <= `RST_INVERT;
      zero_en             <= `RST_ZERO;
      reg_slot            <= `RST_SLOT;
      auto_conv_switch_en <= `RST_AUTO_SWITCH;
    end else if (wr_en) begin
      case (idx)
        `IDX_CLOCK_FORMAT: begin
          soft_reset_n   <= pwdata_in[`POS_SOFT_RESET];
          reg_format     <= pwdata_in[`POS_FORMAT_LO +: 3];
          reg_clock_auto <= pwdata_in[`POS_CLOCK_AUTO];
        end
        `IDX_MUTE: reg_mute <= pwdata_in[0];
        `IDX_CONV_SEL: begin
          conv_mode_sel   <= pwdata_in[`POS_CONV_SEL];
          channel_pick[0] <= pwdata_in[`POS_PICK_1];
        end
        `IDX_INVERT_A: begin
          left_invert[1:0] <= pwdata_in[1:0];
          channel_pick[1]  <= pwdata_in[`POS_PICK_2];
        end
        `IDX_ZERO_LEFT:   zero_en[3:0]     <= pwdata_in[3:0];
        `IDX_ZERO_RIGHT:  zero_en[7:4]     <= pwdata_in[3:0];
        `IDX_SLOT_FORMAT: reg_slot         <= pwdata_in[1:0];
        `IDX_INVERT_B:    left_invert[7:2] <= pwdata_in[5:0];
        `IDX_PICK_B:      channel_pick[3:2] <= pwdata_in[1:0];
        `IDX_AUTO_SWITCH: auto_conv_switch_en <= pwdata_in[0];
        default: ;
      endcase
    end
  end

  // Detector and switching state
  logic          dsd_seen;
  logic          active_dsd;
  logic          target_dsd;
  switch_state_e sw_state;
  logic [1:0]    fs_cnt;
  logic [7:0]    bitstream_clock_div;
  logic          clk_d;
  logic          frame_d;
  logic          fs_tick;

  auto_detect #(.GAP_MAX(`DSD_GAP_MAX)) u_detect (
    .ref_clk_in   (ref_clk_in),
    .rst_n_in     (rst_n_in),
    .clear_in     (!pdn_s),
    .clk_pin_in   (pin_s[0]),
    .frame_pin_in (pin_s[1]),
    .dsd_seen_out (dsd_seen)
  );

  // Pin mode is PCM only; auto mode ignores the select bit
  always_comb begin
    if (pin_ctl) begin
      target_dsd = 1'b0;
    end else if (auto_conv_switch_en) begin
      target_dsd = dsd_seen;
    end else begin
      target_dsd = conv_mode_sel;
    end
  end

  // Sample period tick: frame clock in PCM, divided clock in DSD
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_d    <= 1'b0;
      frame_d  <= 1'b0;
      bitstream_clock_div <= 8'h00;
    end else begin
      clk_d   <= pin_s[0];
      frame_d <= pin_s[1];
      if (!active_dsd) begin
        bitstream_clock_div <= 8'h00;
      end else if (pin_s[0] && !clk_d) begin
        bitstream_clock_div <= (bitstream_clock_div == 8'(DSD_RATIO - 1)) ? 8'h00
                                                    : bitstream_clock_div + 8'h01;
      end
    end
  end
  assign fs_tick = active_dsd ?
                   (pin_s[0] && !clk_d && bitstream_clock_div == 8'(DSD_RATIO - 1)) :
                   (pin_s[1] && !frame_d);

  // Mode change waits out SWITCH_FS sample periods with data muted
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_state   <= st_run;
      fs_cnt     <= 2'h0;
      active_dsd <= 1'b0;
    end else if (!pdn_s) begin
      sw_state   <= st_run;
      fs_cnt     <= 2'h0;
      active_dsd <= 1'b0;
    end else begin
      case (sw_state)
        st_run: begin
          fs_cnt <= 2'h0;
          if (target_dsd != active_dsd) begin
            sw_state <= st_switch;
          end
        end
        st_switch: begin
          if (fs_tick) begin
            if (fs_cnt == 2'(SWITCH_FS - 1)) begin
              active_dsd <= target_dsd;
              sw_state   <= st_run;
            end else begin
              fs_cnt <= fs_cnt + 2'h1;
            end
          end
        end
        default: sw_state <= st_run;
      endcase
    end
  end

  // Effective settings; in pin mode clock setting auto is forced on and the other register-only features held at default
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clock_setting_auto_out <= 1'b0;
      audio_format_out       <= `RST_FORMAT;
      multislot_out          <= `RST_SLOT;
      soft_mute_out          <= 1'b0;
      zero_detect_en_out     <= `RST_ZERO;
      invert_out             <= `RST_INVERT;
      channel_pick_out       <= `RST_PICK;
      soft_reset_n_out       <= 1'b0;
    end else if (pin_ctl) begin
      clock_setting_auto_out <= 1'b1;
      audio_format_out       <= pfmt_s;
      multislot_out          <= pslot_s;
      soft_mute_out          <= pmute_s;
      zero_detect_en_out     <= `RST_ZERO;
      invert_out             <= `RST_INVERT;
      channel_pick_out       <= `RST_PICK;
      soft_reset_n_out       <= pdn_s;
    end else begin
      clock_setting_auto_out <= reg_clock_auto && !active_dsd;
      audio_format_out       <= reg_format;
      multislot_out          <= reg_slot;
      soft_mute_out          <= reg_mute;
      zero_detect_en_out     <= zero_en;
      invert_out             <= left_invert;
      channel_pick_out       <= channel_pick;
      soft_reset_n_out       <= soft_reset_n && pdn_s;
    end
  end

  // Shared pin routing, all zero while a switch is in progress
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_clock_out       <= 1'b0;
      frame_clock_out     <= 1'b0;
      serial_data_out     <= 4'h0;
      bitstream_clock_out <= 1'b0;
      bitstream_left_out  <= 4'h0;
      bitstream_right_out <= 4'h0;
    end else begin
      bit_clock_out       <= 1'b0;
      frame_clock_out     <= 1'b0;
      serial_data_out     <= 4'h0;
      bitstream_clock_out <= 1'b0;
      bitstream_left_out  <= 4'h0;
      bitstream_right_out <= 4'h0;
      if (sw_state == st_run && !active_dsd) begin
        bit_clock_out   <= pin_s[0];
        frame_clock_out <= pin_s[1];
        serial_data_out <= pin_s[5:2];
      end else if (sw_state == st_run) begin
        bitstream_clock_out <= pin_s[0];
        bitstream_left_out  <= {pin_s[7], pin_s[5], pin_s[3], pin_s[1]};
        bitstream_right_out <= {pin_s[8], pin_s[6], pin_s[4], pin_s[2]};
      end
    end
  end

  assign control_mode_out = ctl_mode;
  assign conv_is_dsd_out  = active_dsd;
  assign switching_out    = (sw_state == st_switch);

  // APB answers in the access cycle; unmapped gets pslverr
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (mapped) begin
      case (idx)
        `IDX_CLOCK_FORMAT: rd_word = {24'h0, reg_clock_auto, 3'h0,
                                      reg_format, soft_reset_n};
        `IDX_MUTE:        rd_word = {31'h0, reg_mute};
        `IDX_CONV_SEL:    rd_word = {29'h0, active_dsd,
                                     channel_pick[0], conv_mode_sel};
        `IDX_INVERT_A:    rd_word = {29'h0, channel_pick[1],
                                     left_invert[1:0]};
        `IDX_ZERO_LEFT:   rd_word = {28'h0, zero_en[3:0]};
        `IDX_ZERO_RIGHT:  rd_word = {28'h0, zero_en[7:4]};
        `IDX_SLOT_FORMAT: rd_word = {30'h0, reg_slot};
        `IDX_INVERT_B:    rd_word = {26'h0, left_invert[7:2]};
        `IDX_PICK_B:      rd_word = {30'h0, channel_pick[3:2]};
        `IDX_AUTO_SWITCH: rd_word = {30'h0, dsd_seen,
                                     auto_conv_switch_en};
        default:          rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Read word caught in the setup cycle, so it stands through the access;
  // status bits may be one cycle old, which software cannot notice
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_out <= rd_word;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_strap_capture;
    (pdn_s && !pdn_d) |=> ctl_mode == decode_ctl($past(bus_s),
                                                 $past(strap_s));
  endproperty
  a_strap_capture: assert property (p_strap_capture)
    else $error("control mode not taken from straps");
  property p_mode_held;
    (pdn_d && pdn_s) |=> $stable(ctl_mode);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("control mode moved outside power-down release");
  property p_pin_pcm;
    pin_ctl && sw_state == st_run |-> !conv_is_dsd_out;
  endproperty
  a_pin_pcm: assert property (p_pin_pcm)
    else $error("DSD active in pin control mode");
  property p_pin_defaults;
    pin_ctl && $past(pin_ctl) |-> invert_out == 8'h00 &&
      zero_detect_en_out == 8'h00 && channel_pick_out == 4'hf;
  endproperty
  a_pin_defaults: assert property (p_pin_defaults)
    else $error("register-only feature active in pin mode");
  property p_reg_ignores_pins;
    !pin_ctl && $past(!pin_ctl) |-> audio_format_out == $past(reg_format);
  endproperty
  a_reg_ignores_pins: assert property (p_reg_ignores_pins)
    else $error("format pins used in register mode");
  // Sample periods seen during a switch, counted apart from fs_cnt
  logic [1:0] sw_ticks;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_ticks <= 2'h0;
    end else if (!switching_out) begin
      sw_ticks <= 2'h0;
    end else if (fs_tick && sw_ticks != 2'h3) begin
      sw_ticks <= sw_ticks + 2'h1;
    end
  end
  property p_switch_bound;
    switching_out |-> sw_ticks < 2'(SWITCH_FS);
  endproperty
  a_switch_bound: assert property (p_switch_bound)
    else $error("switch took too many sample periods");
  property p_manual_sel;
    pdn_s && !pin_ctl && !auto_conv_switch_en && sw_state == st_run &&
      conv_mode_sel != active_dsd |=> switching_out;
  endproperty
  a_manual_sel: assert property (p_manual_sel)
    else $error("manual mode not following select bit");
  property p_auto_sel;
    pdn_s && !pin_ctl && auto_conv_switch_en && sw_state == st_run &&
      dsd_seen != active_dsd |=> switching_out;
  endproperty
  a_auto_sel: assert property (p_auto_sel)
    else $error("auto mode not following detector");
  property p_pcm_route;
    sw_state == st_run && !active_dsd ##1 1 |->
      bit_clock_out == $past(pin_s[0]) &&
      frame_clock_out == $past(pin_s[1]) &&
      serial_data_out == $past(pin_s[5:2]);
  endproperty
  a_pcm_route: assert property (p_pcm_route)
    else $error("PCM routing wrong");
  property p_dsd_route;
    sw_state == st_run && active_dsd ##1 1 |->
      bitstream_clock_out == $past(pin_s[0]) &&
      bitstream_right_out[0] == $past(pin_s[2]) &&
      bitstream_left_out[1] == $past(pin_s[3]);
  endproperty
  a_dsd_route: assert property (p_dsd_route)
    else $error("DSD routing wrong");
  property p_pdn_defaults;
    !pdn_s ##1 !pdn_s |-> !auto_conv_switch_en && !reg_clock_auto &&
      reg_format == `RST_FORMAT && zero_en == 8'h00 &&
      left_invert == 8'h00 && channel_pick == 4'hf;
  endproperty
  a_pdn_defaults: assert property (p_pdn_defaults)
    else $error("register defaults wrong in power-down");

  c_to_dsd:  cover property (!active_dsd ##1 active_dsd);
  c_to_pcm:  cover property (active_dsd ##1 !active_dsd);
  c_pin_ctl: cover property (pdn_s && !pdn_d ##1 pin_ctl);
  c_auto:    cover property (auto_conv_switch_en && dsd_seen);
endmodule : conv_mode_ctrl

// ### mode_cfg.svh
`ifndef MODE_CFG_SVH
`define MODE_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_CLOCK_FORMAT 5'h00
`define IDX_MUTE         5'h01
`define IDX_CONV_SEL     5'h02
`define IDX_INVERT_A     5'h05
`define IDX_ZERO_LEFT    5'h07
`define IDX_ZERO_RIGHT   5'h08
`define IDX_SLOT_FORMAT  5'h0a
`define IDX_INVERT_B     5'h0c
`define IDX_PICK_B       5'h0d
`define IDX_AUTO_SWITCH  5'h15
// Field positions
`define POS_SOFT_RESET   0
`define POS_FORMAT_LO    1
`define POS_CLOCK_AUTO   7
`define POS_CONV_SEL     0
`define POS_PICK_1       1
`define POS_PICK_2       2
// Reset values
`define RST_SOFT_RESET_N 1'h0
`define RST_FORMAT       3'h6
`define RST_CLOCK_AUTO   1'h0
`define RST_CONV_SEL     1'h0
`define RST_PICK         4'hf
`define RST_INVERT       8'h00
`define RST_ZERO         8'h00
`define RST_AUTO_SWITCH  1'h0
`define RST_SLOT         2'h0
`define RST_MUTE         1'h0
// Timing counts, in sample periods and bit clock edges
`define SWITCH_FS        2
`define DSD_RATIO        64
`define DSD_GAP_MAX      8
`endif

// ### mode_pkg.sv
package mode_pkg;
  typedef enum logic [1:0] {
    ctl_serial3 = 2'b00,
    ctl_twowire = 2'b01,
    ctl_pin     = 2'b10
  } ctl_mode_e;
  typedef enum logic [0:0] {
    st_run    = 1'b0,
    st_switch = 1'b1
  } switch_state_e;
endpackage : mode_pkg

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mode_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, power_down_n, bsel, strap;
  logic        pmute, dsd, pready, pslverr, mute, dsd_out, sw, srst;
  logic        cka;
  logic [7:0]  paddr, zero, inv;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0]  pfmt, fmt;
  logic [1:0]  pslot, mode, slot;
  logic [3:0]  pick, sdat, bl, br;
  logic [8:0]  pins;
  logic        errv;
  int          miscompares, n_tests, sw_cycles;

  audio_source SRC (.ref_clk_in(clk), .dsd_in(dsd), .pins_out(pins));

  conv_mode_ctrl #(.DSD_RATIO(4), .SWITCH_FS(2)) DUT (
    .ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .power_down_n_in(power_down_n),
    .bus_select_in(bsel), .pin_mode_strap_in(strap),
    .pin_audio_format_in(pfmt), .pin_multislot_in(pslot),
    .pin_soft_mute_in(pmute), .shared_pin_in(pins),
    .control_mode_out(mode), .conv_is_dsd_out(dsd_out),
    .switching_out(sw), .soft_reset_n_out(srst),
    .clock_setting_auto_out(cka), .audio_format_out(fmt),
    .multislot_out(slot), .soft_mute_out(mute),
    .zero_detect_en_out(zero), .invert_out(inv),
    .channel_pick_out(pick), .bit_clock_out(), .frame_clock_out(),
    .serial_data_out(sdat), .bitstream_clock_out(),
    .bitstream_left_out(bl), .bitstream_right_out(br));

  // Core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [4:0] idx,
                     input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'h1, 32'h0);
      finish_test();
    end
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [4:0] idx, input logic [31:0] exp,
                    input logic e);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
    chk(32'(errv), 32'(e));
  endtask : rd

  // Bounded wait for the conversion mode; counts switch cycles
  task automatic wait_dsd(input logic v);
    int k;
    k = 0;
    sw_cycles = 0;
    while (dsd_out !== v && k < 3000) begin
      @(posedge clk);
      k++;
      if (sw === 1'b1) sw_cycles++;
    end
    if (dsd_out !== v) begin
      chk(32'h1, 32'h0);
      finish_test();
    end
  endtask : wait_dsd

  // Straps change only while held in power-down
  task automatic power(input logic b, input logic s);
    power_down_n <= 1'b0;
    bsel <= b;
    strap <= s;
    repeat (4) @(posedge clk);
    power_down_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : power

  // Register indices and their reset images
  logic [4:0]  ri [8] = '{5'h00, 5'h02, 5'h05, 5'h07, 5'h08, 5'h0c,
                          5'h0d, 5'h15};
  logic [31:0] rv [8] = '{32'hc, 32'h2, 32'h4, 32'h0, 32'h0, 32'h0,
                          32'h3, 32'h0};

  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, power_down_n, bsel, strap, dsd} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pfmt = 3'h2;
    pslot = 2'h1;
    pmute = 1'b1;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    power(1'b0, 1'b0);
    chk(32'(mode), 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(ri[i], rv[i], 1'b0);
    end
    rd(5'h03, 32'h0, 1'b1);
    chk(32'({cka, fmt, slot, mute, zero, inv, pick}),
        32'({1'b0, 3'h6, 3'h0, 16'h0, 4'hf}));
    chk(32'(sdat), 32'ha);
    apb(1'b1, 5'h00, 32'hb);
    apb(1'b1, 5'h01, 32'h1);
    apb(1'b1, 5'h0a, 32'h2);
    @(posedge clk);
    chk(32'({srst, fmt, slot, mute}), 32'h6d);
    apb(1'b1, 5'h00, 32'hc);
    // Manual switch with soft reset held low; source follows later
    apb(1'b1, 5'h02, 32'h3);
    wait_dsd(1'b1);
    // Source frame is 256 clocks: three periods plus pin latency
    chk(32'(sw_cycles > 0 && sw_cycles <= 776), 32'h1);
    // Four source periods after the switch to DSD before DSD data
    repeat (4 * 256) @(posedge clk);
    dsd <= 1'b1;
    repeat (64) @(posedge clk);
    chk(32'({br, bl[3:1]}), 32'h71);
    rd(5'h02, 32'h7, 1'b0);
    // Automatic mode ignores the select bit and follows the pins
    apb(1'b1, 5'h15, 32'h1);
    apb(1'b1, 5'h02, 32'h2);
    repeat (300) @(posedge clk);
    chk(32'(dsd_out), 32'h1);
    rd(5'h15, 32'h3, 1'b0);
    dsd <= 1'b0;
    wait_dsd(1'b0);
    // Pin control: function pins rule, PCM only
    power(1'b1, 1'b1);
    chk(32'(mode), 32'h2);
    chk(32'({cka, fmt, slot, mute, zero, inv, pick}),
        32'({1'b1, 3'h2, 2'h1, 1'b1, 16'h0, 4'hf}));
    dsd <= 1'b1;
    apb(1'b1, 5'h02, 32'h1);
    repeat (300) @(posedge clk);
    chk(32'(dsd_out), 32'h0);
    strap <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(mode), 32'h2);
    power(1'b1, 1'b0);
    chk(32'(mode), 32'h1);
    finish_test();
  end
endmodule : tb_top
